/* File: logic/alu_pkg.sv */
// Constants, types and register map of the accumulator add/AND datapath.
// Assumes one 25 MHz system clock, a decoder port and a synchronous RAM.
//
// Notes on behaviour
// RULE_01: Add with carry: work + memory byte + carry into work, five flags.
// RULE_02: Add with carry to memory: same sum written back, five flags.
// RULE_03: Plain add from memory into work register, no carry-in, five flags.
// RULE_04: Add immediate constant to work register, five flags updated.
// RULE_05: Plain add, sum written back to memory, five flags updated.
// RULE_06: AND memory byte into work register; only zero flag changes.
// RULE_07: AND immediate constant into work register; only zero flag changes.
// RULE_08: AND into memory; work register kept; only zero flag changes.
// RULE_09: Carry-in is the carry flag held before the operation starts.
package alu_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int PADDR_W = 8;

    // ************************************************************
    // Register map (byte addresses on APB)
    // ************************************************************
    localparam logic [PADDR_W-1:0] WORK_OFS   = 8'h00;
    localparam logic [PADDR_W-1:0] FLAGS_OFS  = 8'h04;
    localparam logic [PADDR_W-1:0] STATUS_OFS = 8'h08;
    localparam logic [PADDR_W-1:0] RESULT_OFS = 8'h0C;

    // Flag field positions in the flags register
    localparam int FLAG_C_POS  = 0;
    localparam int FLAG_AC_POS = 1;
    localparam int FLAG_Z_POS  = 2;
    localparam int FLAG_OV_POS = 3;
    localparam int FLAG_SC_POS = 4;

    // Status field positions
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_CNT_POS  = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [DATA_W-1:0] WORK_RST   = 8'h00;
    localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
    localparam logic [15:0]       CNT_RST    = 16'h0000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        OP_ADC_A = 3'b000,
        OP_ADC_M = 3'b001,
        OP_ADD_A = 3'b010,
        OP_ADD_I = 3'b011,
        OP_ADD_M = 3'b100,
        OP_AND_A = 3'b101,
        OP_AND_I = 3'b110,
        OP_AND_M = 3'b111
    } opCode_t;

    typedef struct packed {
        opCode_t             code;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   imm;
    } opReq_t;

    typedef struct packed {
        logic signedResult;
        logic signedWrap;
        logic zero;
        logic halfCarry;
        logic carry;
    } flags_t;

    localparam flags_t FLAGS_RST = 5'b0_0000;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_READ = 2'b01,
        S_EXEC = 2'b10
    } state_t;

endpackage

/* File: logic/alu_add8.sv */
// Eight-bit adder with carry, half-carry and signed overflow outputs.
// Assumes purely combinational use inside the datapath.
`timescale 1ns/1ns
module alu_add8
(
    // Operands
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       cin,
    // Results
    output logic      [7:0] sum,
    output logic            carry,
    output logic            halfCarry,
    output logic            signedWrap
);

    logic [4:0] lowSum;
    logic [8:0] fullSum;

    always_comb
    begin
        lowSum     = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        fullSum    = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        sum        = fullSum[7:0];
        carry      = fullSum[8];
        halfCarry  = lowSum[4];
        signedWrap = (a[7] == b[7]) && (fullSum[7] != a[7]);
    end

endmodule

/* File: logic/accumulator_add_and_logic_ops.sv */
// Add and AND datapath around the working register and five flags.
// Assumes a decoder with valid/ready, a RAM with one-cycle read latency
// and an APB master on the same clock.
`timescale 1ns/1ns
module accumulator_add_and_logic_ops
(
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rst_b,
    // Decoder port
    input  wire logic                          opValid,
    input  wire alu_pkg::opReq_t               opReq,
    output logic                               opReady,
    output logic                               opDone,
    // Data memory port
    output logic                               memRd,
    output logic                               memWr,
    output logic [alu_pkg::ADDR_W-1:0]         memAddr,
    output logic [alu_pkg::DATA_W-1:0]         memWdata,
    input  wire logic [alu_pkg::DATA_W-1:0]    memRdata,
    // Core state
    output logic [alu_pkg::DATA_W-1:0]         workingRegister,
    output alu_pkg::flags_t                    flags,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [alu_pkg::PADDR_W-1:0]   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic                               pready,
    output logic [31:0]                        prdata,
    output logic                               pslverr
);
    import alu_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    state_t              state;
    state_t              next_state;
    opReq_t              opReg;
    opReq_t              next_opReg;
    flags_t              next_flags;
    logic [DATA_W-1:0]   next_workingRegister;
    logic [DATA_W-1:0]   lastResult;
    logic [DATA_W-1:0]   next_lastResult;
    logic [15:0]         opCount;
    logic [15:0]         next_opCount;
    logic                next_opReady;
    logic                next_opDone;
    logic                next_memRd;
    logic                next_memWr;
    logic [ADDR_W-1:0]   next_memAddr;
    logic [DATA_W-1:0]   next_memWdata;
    logic                next_pready;
    logic [31:0]         next_prdata;
    logic                next_pslverr;

    logic                opTaken;
    logic                accessEnd;
    logic                wrWork;
    logic                wrFlags;
    logic                addrHit;
    logic [DATA_W-1:0]   operand;
    logic                carryIn;
    logic                isAnd;
    logic                toMemory;
    logic [DATA_W-1:0]   addSum;
    logic                addCarry;
    logic                addHalf;
    logic                addWrap;
    logic [DATA_W-1:0]   result;

    // ************************************************************
    // Adder
    // ************************************************************
    alu_add8 adder
    (
        .a          (workingRegister),
        .b          (operand),
        .cin        (carryIn),
        .sum        (addSum),
        .carry      (addCarry),
        .halfCarry  (addHalf),
        .signedWrap (addWrap)
    );

    // ************************************************************
    // Operand selection and result
    // ************************************************************
    always_comb
    begin
        isAnd    = (opReg.code == OP_AND_A) || (opReg.code == OP_AND_I)
                   || (opReg.code == OP_AND_M);
        toMemory = (opReg.code == OP_ADC_M) || (opReg.code == OP_ADD_M)
                   || (opReg.code == OP_AND_M);
        if ((opReg.code == OP_ADD_I) || (opReg.code == OP_AND_I))
        begin
            operand = opReg.imm;
        end
        else
        begin
            operand = memRdata;
        end
        // Carry comes from the flag register, not from this sum
        if ((opReg.code == OP_ADC_A) || (opReg.code == OP_ADC_M))
        begin
            carryIn = flags.carry; // RULE_09
        end
        else
        begin
            carryIn = 1'b0; // RULE_03 RULE_05
        end
        if (isAnd)
        begin
            result = workingRegister & operand; // RULE_06 RULE_07 RULE_08
        end
        else
        begin
            result = addSum; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05
        end
    end

    // ************************************************************
    // APB decode
    // ************************************************************
    always_comb
    begin
        accessEnd = psel && penable && pready;
        addrHit   = (paddr == WORK_OFS) || (paddr == FLAGS_OFS)
                    || (paddr == STATUS_OFS) || (paddr == RESULT_OFS);
        wrWork    = accessEnd && pwrite && (paddr == WORK_OFS);
        wrFlags   = accessEnd && pwrite && (paddr == FLAGS_OFS);
    end

    always_comb
    begin
        next_pready  = 1'b0;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        // Answer only while the datapath is idle and not taking an op
        if (psel && penable && !pready && (state == S_IDLE) && !opTaken)
        begin
            next_pready  = 1'b1;
            next_pslverr = !addrHit;
            next_prdata  = 32'h0000_0000;
            if (!pwrite)
            begin
                case (paddr)
                    WORK_OFS:
                    begin
                        next_prdata[DATA_W-1:0] = workingRegister;
                    end
                    FLAGS_OFS:
                    begin
                        next_prdata[FLAG_C_POS]  = flags.carry;
                        next_prdata[FLAG_AC_POS] = flags.halfCarry;
                        next_prdata[FLAG_Z_POS]  = flags.zero;
                        next_prdata[FLAG_OV_POS] = flags.signedWrap;
                        next_prdata[FLAG_SC_POS] = flags.signedResult;
                    end
                    STATUS_OFS:
                    begin
                        next_prdata[STAT_BUSY_POS] = (state != S_IDLE);
                        next_prdata[STAT_CNT_POS +: 16] = opCount;
                    end
                    RESULT_OFS:
                    begin
                        next_prdata[DATA_W-1:0] = lastResult;
                    end
                    default:
                    begin
                        next_prdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ************************************************************
    // Sequencer and core state
    // ************************************************************
    always_comb
    begin
        opTaken              = opValid && opReady;
        next_state           = state;
        next_opReg           = opReg;
        next_workingRegister = workingRegister;
        next_flags           = flags;
        next_lastResult      = lastResult;
        next_opCount         = opCount;
        next_opDone          = 1'b0;
        next_memRd           = 1'b0;
        next_memWr           = 1'b0;
        next_memAddr         = memAddr;
        next_memWdata        = memWdata;
        case (state)
            S_IDLE:
            begin
                if (opTaken)
                begin
                    next_opReg   = opReq;
                    next_memAddr = opReq.addr;
                    if ((opReq.code == OP_ADD_I) || (opReq.code == OP_AND_I))
                    begin
                        next_state = S_EXEC;
                    end
                    else
                    begin
                        next_state = S_READ;
                        next_memRd = 1'b1;
                    end
                end
                else
                begin
                    if (wrWork)
                    begin
                        next_workingRegister = pwdata[DATA_W-1:0];
                    end
                    if (wrFlags)
                    begin
                        next_flags.carry        = pwdata[FLAG_C_POS];
                        next_flags.halfCarry    = pwdata[FLAG_AC_POS];
                        next_flags.zero         = pwdata[FLAG_Z_POS];
                        next_flags.signedWrap   = pwdata[FLAG_OV_POS];
                        next_flags.signedResult = pwdata[FLAG_SC_POS];
                    end
                end
            end
            S_READ:
            begin
                next_state = S_EXEC;
            end
            S_EXEC:
            begin
                next_state      = S_IDLE;
                next_opDone     = 1'b1;
                next_lastResult = result;
                next_opCount    = opCount + 16'h0001;
                next_flags.zero = (result == 8'h00); // RULE_06 RULE_07
                if (!isAnd)
                begin
                    // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05
                    next_flags.carry        = addCarry;
                    next_flags.halfCarry    = addHalf;
                    next_flags.signedWrap   = addWrap;
                    next_flags.signedResult = addWrap ^ addSum[7];
                end
                if (toMemory)
                begin
                    // Work register kept for memory destinations
                    next_memWr    = 1'b1; // RULE_02 RULE_05 RULE_08
                    next_memWdata = result;
                end
                else
                begin
                    next_workingRegister = result; // RULE_01 RULE_03
                end
            end
            default:
            begin
                next_state = S_IDLE;
            end
        endcase
        next_opReady = (next_state == S_IDLE) && !psel;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state           <= S_IDLE;
            opReg           <= '0;
            workingRegister <= WORK_RST;
            flags           <= FLAGS_RST;
            lastResult      <= RESULT_RST;
            opCount         <= CNT_RST;
            opReady         <= 1'b0;
            opDone          <= 1'b0;
            memRd           <= 1'b0;
            memWr           <= 1'b0;
            memAddr         <= 8'h00;
            memWdata        <= 8'h00;
        end
        else
        begin
            state           <= next_state;
            opReg           <= next_opReg;
            workingRegister <= next_workingRegister;
            flags           <= next_flags;
            lastResult      <= next_lastResult;
            opCount         <= next_opCount;
            opReady         <= next_opReady;
            opDone          <= next_opDone;
            memRd           <= next_memRd;
            memWr           <= next_memWr;
            memAddr         <= next_memAddr;
            memWdata        <= next_memWdata;
        end
    end

endmodule

/* File: dv/data_ram_model.sv */
// Behavioural data RAM on the datapath's memory port.
// Assumes one clock; read data one cycle after a read strobe.
`timescale 1ns/1ns
module data_ram_model
(
    // Clock
    input  wire logic       clk_sys,
    // Memory port
    input  wire logic       memRd,
    input  wire logic       memWr,
    input  wire logic [7:0] memAddr,
    input  wire logic [7:0] memWdata,
    output logic      [7:0] memRdata
);
    logic [7:0] mem [256];
    always @(posedge clk_sys)
    begin
        if (memWr)
            mem[memAddr] <= memWdata;
        // Read data stands one cycle, then the bus toggles
        if (memRd)
            memRdata <= mem[memAddr];
        else
            memRdata <= ~memRdata;
    end
endmodule

/* File: dv/alu_ops_props.sv */
// Checker for the add/AND datapath, bound to its top module.
// Assumes read data returns one cycle after memRd.
`timescale 1ns/1ns
module alu_ops_props
    import alu_pkg::*;
(
    input wire logic            clk_sys,
    input wire logic            rst_b,
    input wire logic            opValid,
    input wire alu_pkg::opReq_t opReq,
    input wire logic            opReady,
    input wire logic            opDone,
    input wire logic            memRd,
    input wire logic            memWr,
    input wire logic [7:0]      memAddr,
    input wire logic [7:0]      memWdata,
    input wire logic [7:0]      memRdata,
    input wire logic [7:0]      workingRegister,
    input wire alu_pkg::flags_t flags
);
    opCode_t    cOp;
    logic [7:0] cW, cM, cI, cA, opB, res;
    flags_t     cF, expF;
    logic       rdSeen, cin, addOp, take, immReq;
    logic [8:0] sum;
    logic [4:0] nib;
    assign take   = opValid && opReady;
    assign immReq = opReq.code == OP_ADD_I || opReq.code == OP_AND_I;
    // Operands captured at take time; memory byte captured one cycle after memRd
    always_ff @(posedge clk_sys)
    begin
        if (take)
        begin
            cOp <= opReq.code;
            cI  <= opReq.imm;
            cA  <= opReq.addr;
            cW  <= workingRegister;
            cF  <= flags;
        end
        if (rdSeen)
            cM <= memRdata;
        rdSeen <= memRd;
    end
    always_comb
    begin
        addOp = cOp <= OP_ADD_M;
        opB   = (cOp == OP_ADD_I || cOp == OP_AND_I) ? cI : cM;
        cin   = (cOp == OP_ADC_A || cOp == OP_ADC_M) ? cF.carry : 1'b0;
        sum   = {1'b0, cW} + {1'b0, opB} + {8'h00, cin};
        nib   = {1'b0, cW[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
        res   = addOp ? sum[7:0] : (cW & opB);
        expF  = cF;
        expF.zero = res == 8'h00;
        if (addOp)
        begin
            expF.carry = sum[8];
            expF.halfCarry = nib[4];
            expF.signedWrap = (cW[7] == opB[7]) && (sum[7] != cW[7]);
            expF.signedResult = expF.signedWrap ^ sum[7];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_mem_walk;
        memRd ##1 !memRd ##1 opDone;
    endsequence
    sequence s_imm_walk;
        !opDone ##1 (opDone && !memWr);
    endsequence
    property p_work(opCode_t c);
        opDone && cOp == c |-> workingRegister == res && flags == expF;
    endproperty
    property p_mem(opCode_t c);
        opDone && cOp == c |-> memWr && memWdata == res && memAddr == cA
            && workingRegister == cW && flags == expF;
    endproperty
    a_adc_work: assert property (p_work(OP_ADC_A))
        else $error("add with carry to work wrong");
    a_adc_mem: assert property (p_mem(OP_ADC_M))
        else $error("add with carry to memory wrong");
    a_add_work: assert property (p_work(OP_ADD_A))
        else $error("add to work wrong");
    a_add_imm: assert property (p_work(OP_ADD_I))
        else $error("add immediate wrong");
    a_add_mem: assert property (p_mem(OP_ADD_M))
        else $error("add to memory wrong");
    a_and_work: assert property (p_work(OP_AND_A))
        else $error("and to work wrong");
    a_and_imm: assert property (p_work(OP_AND_I))
        else $error("and immediate wrong");
    a_and_mem: assert property (p_mem(OP_AND_M))
        else $error("and to memory wrong");
    a_mem_walk: assert property (take && !immReq |=> s_mem_walk)
        else $error("memory op sequence wrong");
    a_imm_walk: assert property (take && immReq |=> s_imm_walk)
        else $error("immediate op sequence wrong");
endmodule
bind accumulator_add_and_logic_ops alu_ops_props i_props
(
    .clk_sys(clk_sys), .rst_b(rst_b), .opValid(opValid), .opReq(opReq),
    .opReady(opReady), .opDone(opDone), .memRd(memRd), .memWr(memWr),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
    .workingRegister(workingRegister), .flags(flags)
);

/* File: dv/testbench.sv */
// Self-checking bench: register access and every add/AND operation.
// Assumes the RAM model and the bound checker.
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
    miscompares++; \
    $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module testbench
    import alu_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        opValid = 1'b0;
    opReq_t      opReq = '0;
    logic        opReady, opDone, memRd, memWr, pready, pslverr, er;
    logic [7:0]  memAddr, memWdata, memRdata, workingRegister;
    flags_t      flags;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    int          miscompares = 0, cmp_count = 0;
    accumulator_add_and_logic_ops i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .opValid(opValid), .opReq(opReq), .opReady(opReady),
        .opDone(opDone), .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
        .memWdata(memWdata), .memRdata(memRdata),
        .workingRegister(workingRegister), .flags(flags), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    data_ram_model i_ram (.clk_sys(clk_sys), .memRd(memRd), .memWr(memWr),
        .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));
    always #20 clk_sys = ~clk_sys;
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            miscompares++;
        @(posedge clk_sys);
    endtask
    task automatic do_op(input opCode_t c, input logic [7:0] a, i);
        int n = 0;
        opValid <= 1'b1;
        opReq   <= {c, a, i};
        do @(posedge clk_sys); while (opReady !== 1'b1 && ++n < 20);
        opValid <= 1'b0;
        do @(posedge clk_sys); while (opDone !== 1'b1 && ++n < 40);
        if (n >= 40)
            miscompares++;
        // One more edge so a memory write-back has landed
        @(posedge clk_sys);
    endtask
    task automatic t_regs();
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b0, 8'(k * 4), 32'h0000_0000);
            `CHK(rd, 32'h0000_0000)
            `CHK(er, 1'b0)
        end
        apb(1'b1, WORK_OFS, 32'h0000_005A);
        apb(1'b0, WORK_OFS, 32'h0000_0000);
        `CHK(rd, 32'h0000_005A)
        apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
        `CHK(er, 1'b0)
        apb(1'b0, STATUS_OFS, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, 8'h10, 32'h0000_0000);
        `CHK({er, rd}, {1'b1, 32'h0000_0000})
        $display("t_regs done");
    endtask
    task automatic t_ops();
        opCode_t    c [8] = '{OP_ADC_A, OP_ADC_M, OP_ADD_A, OP_ADD_I,
                              OP_ADD_M, OP_AND_A, OP_AND_I, OP_AND_M};
        logic [7:0] w [8] = '{8'hFF, 8'h7F, 8'h80, 8'h08,
                              8'h01, 8'hF0, 8'hF0, 8'hAA};
        logic [7:0] f [8] = '{8'h01, 8'h01, 8'h01, 8'h00,
                              8'h1F, 8'h1B, 8'h04, 8'h13};
        logic [7:0] m [8] = '{8'h00, 8'h00, 8'h80, 8'h55,
                              8'hFE, 8'h0F, 8'h00, 8'h0F};
        logic [7:0] i [8] = '{8'h00, 8'h00, 8'h00, 8'h08,
                              8'h00, 8'h00, 8'h3C, 8'h00};
        logic [7:0] r [8] = '{8'h00, 8'h80, 8'h00, 8'h10,
                              8'hFF, 8'h00, 8'h30, 8'h0A};
        logic [4:0] e [8] = '{5'h07, 5'h0A, 5'h1D, 5'h02,
                              5'h10, 5'h1F, 5'h00, 5'h13};
        logic [7:0] a;
        logic       toMem;
        for (int k = 0; k < 8; k++)
        begin
            a = 8'(k * 37 + 5);
            toMem = c[k] inside {OP_ADC_M, OP_ADD_M, OP_AND_M};
            i_ram.mem[a] = m[k];
            apb(1'b1, WORK_OFS, {24'h00_0000, w[k]});
            apb(1'b1, FLAGS_OFS, {24'h00_0000, f[k]});
            do_op(c[k], a, i[k]);
            `CHK(workingRegister, toMem ? w[k] : r[k])
            `CHK(i_ram.mem[a], toMem ? r[k] : m[k])
            `CHK(flags, e[k])
        end
        $display("t_ops done");
    endtask
    task automatic t_chain();
        apb(1'b1, WORK_OFS, 32'h0000_0010);
        apb(1'b1, FLAGS_OFS, 32'h0000_0000);
        i_ram.mem[8'h40] = 8'hFF;
        do_op(OP_ADD_I, 8'h00, 8'h20);
        do_op(OP_ADD_I, 8'h00, 8'hF0);
        `CHK(flags, 5'h01)
        do_op(OP_ADC_A, 8'h40, 8'h00);
        `CHK({workingRegister, flags}, {8'h20, 5'h03})
        apb(1'b0, STATUS_OFS, 32'h0000_0000);
        `CHK(rd, 32'h0000_0B00)
        apb(1'b0, RESULT_OFS, 32'h0000_0000);
        `CHK(rd, 32'h0000_0020)
        $display("t_chain done");
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_ops();
        t_chain();
        test_done();
    end
    initial
    begin
        #100000;
        miscompares++;
        test_done();
    end
endmodule
